// [logic/psd_host.sv]
// Host controller: AHB-Lite registers driving the configuration pins
`timescale 1ns/1ns
`include "psd_defs.svh"
module psd_host
    import psd_pkg::*;
#(
    parameter int LOCK_CYCLES = `PSD_LOCK_CYC,
    parameter int SCLK_HALF   = `PSD_SCLK_HALF_CYC,
    parameter int TEST_HALF   = `PSD_TEST_HALF_CYC,
    parameter int PW_CYCLES   = `PSD_PW_CYC
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Configuration pins
    psd_if.host              link
);
    localparam int LW = $clog2(LOCK_CYCLES + 1);

    psd_host_state_t       st_q;
    psd_host_state_t       st_d;
    logic [`PSD_SR_LEN-1:0] cfg_q;
    logic [`PSD_SR_LEN-1:0] cfg_d;
    logic                  drv_q;
    logic                  drv_d;
    logic                  tst_q;
    logic                  tst_d;
    logic                  wr_q;
    logic                  wr_d;
    logic [7:0]            wa_q;
    logic [7:0]            wa_d;
    logic [31:0]           rd_q;
    logic [31:0]           rd_d;
    logic                  go_ser;
    logic                  go_par;
    logic                  m_bad;
    logic                  test6;
    logic [3:0]            tmr_q;
    logic [3:0]            tmr_d;
    logic [3:0]            bit_q;
    logic [3:0]            bit_d;
    logic [`PSD_SR_LEN-1:0] sh_q;
    logic [`PSD_SR_LEN-1:0] sh_d;
    logic                  sclk_q;
    logic                  sclk_d;
    logic                  sload_q;
    logic                  sload_d;
    logic                  pl_n_q;
    logic                  pl_n_d;
    logic                  ref_q;
    logic                  ref_d;
    logic                  reload;
    logic [LW-1:0]         lock_q;
    logic [LW-1:0]         lock_d;

    // Register slave, zero wait states
    always_comb begin
        wr_d   = hsel_i & htrans_i[1] & hready_i & hwrite_i;
        wa_d   = haddr_i[7:0];
        rd_d   = 32'h0000_0000;
        cfg_d  = cfg_q;
        drv_d  = drv_q;
        tst_d  = tst_q;
        go_ser = 1'b0;
        go_par = 1'b0;
        if (hsel_i && htrans_i[1] && hready_i && !hwrite_i) begin
            case (haddr_i[7:0])
                `PSD_OFS_CTRL: begin
                    rd_d[`PSD_CTRL_DRV] = drv_q;
                    rd_d[`PSD_CTRL_TST] = tst_q;
                end
                `PSD_OFS_CFG:  rd_d[`PSD_SR_LEN-1:0] = cfg_q;
                `PSD_OFS_STAT: begin
                    rd_d[`PSD_STAT_BUSY]    = (st_q != HST_IDLE);
                    rd_d[`PSD_STAT_SETTLED] = (lock_q == '0);
                    rd_d[`PSD_STAT_REFUSED] = ref_q;
                    rd_d[`PSD_STAT_PLOAD]   = pl_n_q;
                end
                default: rd_d = 32'h0000_0000;
            endcase
        end
        if (wr_q) begin
            case (wa_q)
                `PSD_OFS_CTRL: begin
                    go_ser = hwdata_i[`PSD_CTRL_SER];
                    go_par = hwdata_i[`PSD_CTRL_PAR];
                    drv_d  = hwdata_i[`PSD_CTRL_DRV];
                    tst_d  = hwdata_i[`PSD_CTRL_TST];
                end
                `PSD_OFS_CFG: cfg_d = hwdata_i[`PSD_SR_LEN-1:0];
                default: cfg_d = cfg_q;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            wr_q        <= 1'b0;
            wa_q        <= 8'h00;
            rd_q        <= 32'h0000_0000;
            cfg_q       <= `PSD_CFG_RST;
            drv_q       <= 1'b0;
            tst_q       <= 1'b0;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_q        <= wr_d;
            wa_q        <= wa_d;
            rd_q        <= rd_d;
            cfg_q       <= cfg_d;
            drv_q       <= drv_d;
            tst_q       <= tst_d;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // Pin sequencer
    always_comb begin
        m_bad   = (cfg_q[8:0] < `PSD_M_MIN) || (cfg_q[8:0] > `PSD_M_MAX);
        test6   = tst_q && (cfg_q[`PSD_SR_LEN-1:`PSD_CFG_T_LSB] == OBS_SCLK);
        st_d    = st_q;
        tmr_d   = (tmr_q != 4'h0) ? tmr_q - 4'h1 : 4'h0;
        bit_d   = bit_q;
        sh_d    = sh_q;
        sclk_d  = sclk_q;
        sload_d = sload_q;
        pl_n_d  = pl_n_q;
        ref_d   = ref_q;
        reload  = 1'b0;
        case (st_q)
            HST_IDLE: begin
                if ((go_par || go_ser) && m_bad) begin
                    ref_d = 1'b1;
                end else if (go_par) begin
                    ref_d  = 1'b0;
                    pl_n_d = 1'b0;
                    tmr_d  = 4'(PW_CYCLES - 1);
                    st_d   = HST_PAR_LOW;
                end else if (go_ser && !pl_n_q) begin
                    ref_d = 1'b1;
                end else if (go_ser) begin
                    ref_d = 1'b0;
                    sh_d  = cfg_q;
                    bit_d = 4'(`PSD_SR_LEN - 1);
                    tmr_d = 4'(SCLK_HALF - 1);
                    st_d  = HST_SHIFT_LO;
                end else if (test6) begin
                    tmr_d = 4'(TEST_HALF - 1);
                    st_d  = HST_TEST;
                end
            end
            HST_SHIFT_LO: begin
                if (tmr_q == 4'h0) begin
                    sclk_d = 1'b1;
                    tmr_d  = 4'(SCLK_HALF - 1);
                    st_d   = HST_SHIFT_HI;
                end
            end
            HST_SHIFT_HI: begin
                if (tmr_q == 4'h0) begin
                    sclk_d = 1'b0;
                    tmr_d  = 4'(SCLK_HALF - 1);
                    if (bit_q == 4'h0) begin
                        sload_d = 1'b1;
                        tmr_d   = 4'(PW_CYCLES - 1);
                        st_d    = HST_STROBE;
                    end else begin
                        bit_d = bit_q - 4'h1;
                        sh_d  = {sh_q[`PSD_SR_LEN-2:0], 1'b0};
                        st_d  = HST_SHIFT_LO;
                    end
                end
            end
            HST_STROBE: begin
                if (tmr_q == 4'h0) begin
                    sload_d = 1'b0;
                    reload  = 1'b1;
                    st_d    = HST_IDLE;
                end
            end
            HST_PAR_LOW: begin
                if (tmr_q == 4'h0) begin
                    pl_n_d = 1'b1;
                    reload = 1'b1;
                    st_d   = HST_IDLE;
                end
            end
            HST_TEST: begin
                // Fast clock only as a test clock, never for loading
                if (!test6) begin
                    sclk_d = 1'b0;
                    st_d   = HST_IDLE;
                end else if (tmr_q == 4'h0) begin
                    sclk_d = ~sclk_q;
                    tmr_d  = 4'(TEST_HALF - 1);
                end
            end
            default: st_d = HST_IDLE;
        endcase
        if (reload) begin
            lock_d = LW'(LOCK_CYCLES);
        end else if (lock_q != '0) begin
            lock_d = lock_q - 1'b1;
        end else begin
            lock_d = lock_q;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            st_q    <= HST_IDLE;
            tmr_q   <= 4'h0;
            bit_q   <= 4'h0;
            sh_q    <= '0;
            sclk_q  <= 1'b0;
            sload_q <= 1'b0;
            pl_n_q  <= 1'b0;
            ref_q   <= 1'b0;
            lock_q  <= '0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            bit_q   <= bit_d;
            sh_q    <= sh_d;
            sclk_q  <= sclk_d;
            sload_q <= sload_d;
            pl_n_q  <= pl_n_d;
            ref_q   <= ref_d;
            lock_q  <= lock_d;
        end
    end

    assign hrdata_o      = rd_q;
    assign link.m_out    = cfg_q[8:0];
    assign link.n_out    = cfg_q[`PSD_CFG_T_LSB-1:`PSD_CFG_N_LSB];
    assign link.par_oe   = drv_q;
    assign link.p_load_n = pl_n_q;
    assign link.s_clock  = sclk_q;
    assign link.s_data   = sh_q[`PSD_SR_LEN-1];
    assign link.s_load   = sload_q;
endmodule

// [logic/psd_defs.svh]
// Offsets, field positions, reset values and timing counts
`ifndef PSD_DEFS_SVH
`define PSD_DEFS_SVH

`define PSD_CLK_PERIOD_NS 10
`define PSD_SCLK_MAX_MHZ  10
`define PSD_SCLK_HALF_CYC ((1000 / `PSD_SCLK_MAX_MHZ / 2 + \
    `PSD_CLK_PERIOD_NS - 1) / `PSD_CLK_PERIOD_NS)
`define PSD_TEST_HALF_CYC 2
`define PSD_T_PW_NS       50
`define PSD_PW_CYC        ((`PSD_T_PW_NS + `PSD_CLK_PERIOD_NS - 1) / \
    `PSD_CLK_PERIOD_NS)
`define PSD_T_LOCK_MS     10
`define PSD_LOCK_CYC      (`PSD_T_LOCK_MS * 1000000 / `PSD_CLK_PERIOD_NS)

`define PSD_REF_DIV       16
`define PSD_M_MIN         9'h0C8
`define PSD_M_MAX         9'h190
`define PSD_SR_LEN        14

`define PSD_OFS_CTRL      8'h00
`define PSD_OFS_CFG       8'h04
`define PSD_OFS_STAT      8'h08

`define PSD_CTRL_SER      0
`define PSD_CTRL_PAR      1
`define PSD_CTRL_DRV      2
`define PSD_CTRL_TST      3
`define PSD_CFG_T_LSB     11
`define PSD_CFG_N_LSB     9
`define PSD_STAT_BUSY     0
`define PSD_STAT_SETTLED  1
`define PSD_STAT_REFUSED  2
`define PSD_STAT_PLOAD    3

`define PSD_CFG_RST       14'h00C8
`define PSD_M_RST         9'h1FF
`define PSD_N_RST         2'h3

`endif

// [logic/psd_pkg.sv]
// Types shared by both ends of the synthesizer configuration link
package psd_pkg;
    typedef enum logic [2:0] {
        HST_IDLE     = 3'h0,
        HST_SHIFT_LO = 3'h1,
        HST_SHIFT_HI = 3'h3,
        HST_STROBE   = 3'h2,
        HST_PAR_LOW  = 3'h6,
        HST_TEST     = 3'h4
    } psd_host_state_t;

    typedef enum logic [1:0] {
        NDIV_2 = 2'h0,
        NDIV_4 = 2'h1,
        NDIV_8 = 2'h2,
        NDIV_1 = 2'h3
    } psd_ndiv_t;

    typedef enum logic [2:0] {
        OBS_QUIET = 3'h0,
        OBS_CMP   = 3'h1,
        OBS_FB    = 3'h2,
        OBS_VCO   = 3'h3,
        OBS_SYNTH = 3'h4,
        OBS_UP    = 3'h5,
        OBS_SCLK  = 3'h6,
        OBS_DOWN  = 3'h7
    } psd_obs_t;
endpackage

// [logic/psd_if.sv]
// Parallel and serial configuration pins between host and device
`timescale 1ns/1ns
interface psd_if;
    logic [8:0] m_out;
    logic [1:0] n_out;
    logic       par_oe;
    logic       p_load_n;
    logic       s_clock;
    logic       s_data;
    logic       s_load;
    logic [8:0] m_pin;
    logic [1:0] n_pin;

    // Undriven divider pins float to one
    assign m_pin = par_oe ? m_out : '1;
    assign n_pin = par_oe ? n_out : '1;

    modport host (
        output m_out, n_out, par_oe, p_load_n, s_clock, s_data, s_load
    );
    modport device (
        input m_pin, n_pin, p_load_n, s_clock, s_data, s_load
    );
endinterface

// [logic/psd_sync.sv]
// Two-stage synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ns
module psd_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             reset_i,
    // Bundle
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule

// [logic/psd_device.sv]
// Synthesizer device: configuration latches, dividers, phase detector
`timescale 1ns/1ns
`include "psd_defs.svh"
module psd_device
    import psd_pkg::*;
#(
    parameter int REF_DIV = `PSD_REF_DIV
) (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    // Configuration pins
    psd_if.device           cfg,
    // Reference selection and oscillator inputs
    input  wire logic       ref_select_i,
    input  wire logic       crystal_reference_in_i,
    input  wire logic       external_reference_in_i,
    input  wire logic       vco_clock_i,
    // Loop signals
    output logic            comparison_ref_o,
    output logic            feedback_o,
    output logic            pump_up_o,
    output logic            pump_down_o,
    // Outputs
    output logic            synth_clock_out_o,
    output logic            monitor_o,
    // Configuration view
    output logic [8:0]      loop_divider_o,
    output logic [1:0]      output_divider_o,
    output logic [2:0]      observe_select_o
);
    localparam int SW = 19;
    localparam int RH = REF_DIV / 2;
    localparam int RW = $clog2(RH);

    logic [SW-1:0] raw;
    logic [SW-1:0] syn;
    logic [8:0]    m_s;
    logic [1:0]    n_s;
    logic          pl_s;
    logic          sc_s;
    logic          sd_s;
    logic          sl_s;
    logic          sel_s;
    logic          xt_s;
    logic          ex_s;
    logic          vco_s;
    logic          ref_s;

    // All pins are foreign to this clock, including the references
    assign raw = {cfg.m_pin, cfg.n_pin, cfg.p_load_n, cfg.s_clock,
                  cfg.s_data, cfg.s_load, ref_select_i,
                  crystal_reference_in_i, external_reference_in_i,
                  vco_clock_i};

    psd_sync #(
        .WIDTH (SW)
    ) u_sync (
        .clock_i (clock_i),
        .reset_i (reset_i),
        .async_i (raw),
        .sync_o  (syn)
    );

    assign {m_s, n_s, pl_s, sc_s, sd_s, sl_s, sel_s, xt_s, ex_s,
            vco_s} = syn;
    assign ref_s = sel_s ? xt_s : ex_s;

    // Edge history
    logic [4:0] hist_q;
    logic [4:0] hist_d;
    logic       pl_rise;
    logic       sc_rise;
    logic       sl_fall;
    logic       ref_rise;
    logic       vco_rise;

    always_comb begin
        hist_d   = {pl_s, sc_s, sl_s, ref_s, vco_s};
        pl_rise  = pl_s & ~hist_q[4];
        sc_rise  = sc_s & ~hist_q[3];
        sl_fall  = ~sl_s & hist_q[2];
        ref_rise = ref_s & ~hist_q[1];
        vco_rise = vco_s & ~hist_q[0];
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            hist_q <= 5'h00;
        end else begin
            hist_q <= hist_d;
        end
    end

    // Configuration latches and serial shift register
    logic [`PSD_SR_LEN-1:0] sr_q;
    logic [`PSD_SR_LEN-1:0] sr_d;
    logic [8:0]             m_q;
    logic [8:0]             m_d;
    logic [1:0]             n_q;
    logic [1:0]             n_d;
    logic [2:0]             t_q;
    logic [2:0]             t_d;

    always_comb begin
        sr_d = sr_q;
        m_d  = m_q;
        n_d  = n_q;
        t_d  = t_q;
        if (sc_rise) begin
            sr_d = {sr_q[`PSD_SR_LEN-2:0], sd_s};
        end
        if (pl_rise) begin
            m_d = m_s;
            n_d = n_s;
        end else if (!pl_s) begin
            m_d = m_s;
            n_d = n_s;
            t_d = 3'h0;
        end else if (sl_fall) begin
            // Strobe only reaches here with load high
            t_d = sr_q[`PSD_SR_LEN-1:`PSD_CFG_T_LSB];
            n_d = sr_q[`PSD_CFG_T_LSB-1:`PSD_CFG_N_LSB];
            m_d = sr_q[`PSD_CFG_N_LSB-1:0];
        end
        // Otherwise the last values stand
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            sr_q <= '0;
            m_q  <= `PSD_M_RST;
            n_q  <= `PSD_N_RST;
            t_q  <= 3'h0;
        end else begin
            sr_q <= sr_d;
            m_q  <= m_d;
            n_q  <= n_d;
            t_q  <= t_d;
        end
    end

    // Reference, loop and output dividers
    logic [RW-1:0] refcnt_q;
    logic [RW-1:0] refcnt_d;
    logic          cmp_q;
    logic          cmp_d;
    logic          cmp_tick;
    logic [8:0]    fbcnt_q;
    logic [8:0]    fbcnt_d;
    logic          fb_q;
    logic          fb_d;
    logic [2:0]    outcnt_q;
    logic [2:0]    outcnt_d;

    always_comb begin
        refcnt_d = refcnt_q;
        cmp_d    = cmp_q;
        cmp_tick = 1'b0;
        fbcnt_d  = fbcnt_q;
        fb_d     = 1'b0;
        outcnt_d = outcnt_q;
        if (ref_rise) begin
            if (refcnt_q == RW'(RH - 1)) begin
                refcnt_d = '0;
                cmp_d    = ~cmp_q;
                cmp_tick = ~cmp_q;
            end else begin
                refcnt_d = refcnt_q + 1'b1;
            end
        end
        if (vco_rise) begin
            // Wrap at M edges; M of zero wraps at the full range
            if (fbcnt_q >= m_q - 9'h001) begin
                fbcnt_d = 9'h000;
                fb_d    = 1'b1;
            end else begin
                fbcnt_d = fbcnt_q + 9'h001;
            end
            outcnt_d = outcnt_q + 3'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            refcnt_q <= '0;
            cmp_q    <= 1'b0;
            fbcnt_q  <= 9'h000;
            fb_q     <= 1'b0;
            outcnt_q <= 3'h0;
        end else begin
            refcnt_q <= refcnt_d;
            cmp_q    <= cmp_d;
            fbcnt_q  <= fbcnt_d;
            fb_q     <= fb_d;
            outcnt_q <= outcnt_d;
        end
    end

    // Phase detector and output selection
    logic up_q;
    logic up_d;
    logic dn_q;
    logic dn_d;
    logic synth_q;
    logic synth_d;
    logic mon_q;
    logic mon_d;

    always_comb begin
        up_d = up_q | cmp_tick;
        dn_d = dn_q | fb_q;
        if (up_d && dn_d) begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
        // Counter bits toggle on VCO rises, so duty stays balanced
        case (n_q)
            NDIV_1:  synth_d = vco_s;
            NDIV_2:  synth_d = outcnt_q[0];
            NDIV_4:  synth_d = outcnt_q[1];
            NDIV_8:  synth_d = outcnt_q[2];
            default: synth_d = 1'b0;
        endcase
        case (t_q)
            OBS_QUIET: mon_d = 1'b0;
            OBS_CMP:   mon_d = cmp_q;
            OBS_FB:    mon_d = fb_q;
            OBS_VCO:   mon_d = vco_s;
            OBS_SYNTH: mon_d = synth_q;
            OBS_UP:    mon_d = up_q;
            OBS_SCLK:  mon_d = sc_s;
            OBS_DOWN:  mon_d = dn_q;
            default:   mon_d = 1'b0;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            up_q    <= 1'b0;
            dn_q    <= 1'b0;
            synth_q <= 1'b0;
            mon_q   <= 1'b0;
        end else begin
            up_q    <= up_d;
            dn_q    <= dn_d;
            synth_q <= synth_d;
            mon_q   <= mon_d;
        end
    end

    assign comparison_ref_o  = cmp_q;
    assign feedback_o        = fb_q;
    assign pump_up_o         = up_q;
    assign pump_down_o       = dn_q;
    assign synth_clock_out_o = synth_q;
    assign monitor_o         = mon_q;
    assign loop_divider_o    = m_q;
    assign output_divider_o  = n_q;
    assign observe_select_o  = t_q;
endmodule

// [testbench/psd_checker.sv]
// Wire-level checks on the configuration link
`timescale 1ns/1ns
module psd_checker (
    // Clock and reset
    input wire logic       clock_i,
    input wire logic       reset_i,
    // Link
    input wire logic [8:0] m_out,
    input wire logic [1:0] n_out,
    input wire logic       par_oe,
    input wire logic       p_load_n,
    input wire logic       s_clock,
    input wire logic       s_data,
    input wire logic       s_load,
    input wire logic [8:0] m_pin,
    input wire logic [1:0] n_pin
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    logic [3:0] rises_q;
    logic [3:0] rises_d;
    logic       sclk_q;
    // Rises since the last strobe
    always_comb begin
        rises_d = s_load ? 4'h0 : rises_q + {3'h0, s_clock & ~sclk_q};
    end
    always_ff @(posedge clock_i) begin
        sclk_q  <= reset_i ? 1'b0 : s_clock;
        rises_q <= reset_i ? 4'h0 : rises_d;
    end
    a_pins_pulled_up: assert property (
        !par_oe |-> m_pin == 9'h1FF && n_pin == 2'h3)
        else $error("undriven divider pins not high");
    a_pins_follow: assert property (
        par_oe |-> m_pin == m_out && n_pin == n_out)
        else $error("driven divider pins differ");
    a_frame_length: assert property (
        $rose(s_load) |-> rises_q == 4'hE)
        else $error("frame not fourteen clocks");
    a_sdata_steady: assert property (
        s_clock && $past(s_clock) |-> $stable(s_data))
        else $error("serial data moved while clock high");
    // Test clock mode is not covered by this width check
    a_sclk_high_half: assert property (
        $rose(s_clock) |-> s_clock [*5] ##1 !s_clock)
        else $error("serial clock high half wrong");
    a_load_pulse: assert property (
        $rose(s_load) |-> s_load [*5] ##1 !s_load)
        else $error("strobe width wrong");
    a_load_clock_low: assert property (
        s_load |-> !s_clock && p_load_n)
        else $error("strobe with clock high or load low");
    a_par_pulse: assert property (
        $fell(p_load_n) |-> !p_load_n [*5])
        else $error("parallel load pulse too short");
    cover property ($rose(s_load));
    cover property ($rose(p_load_n));
    cover property ($rose(par_oe));
endmodule

// [testbench/pll_synth_divider_config_test.sv]
// Self-checking bench: host and device joined over the link
`timescale 1ns/1ns
`define CHECK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pll_synth_divider_config_test;
    logic        clock_i = 0, reset_i = 1, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0, n_v, n_e;
    logic        hreadyout, sel = 1, crystal_reference_in = 0, ext = 0, vco = 0;
    logic        cmp, synth, mon, fb, up, dn, hresp;
    logic [8:0]  m_v, m_e;
    logic [2:0]  t_v;
    int          seed = 63, num_errors = 0, comparisons = 0, cycles = 0;
    int          c_r, s_r, f_r, b_r, o_r, ref_c, c_e, s_e, f_e;
    always #5 clock_i = ~clock_i;
    always #40 crystal_reference_in = ~crystal_reference_in;
    always #60 ext = ~ext;
    always #20 vco = ~vco;
    psd_if psd_if_inst ();
    psd_host #(.LOCK_CYCLES(20)) psd_host_inst (
        .clock_i(clock_i), .reset_i(reset_i), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
        .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .link(psd_if_inst));
    psd_device psd_device_inst (
        .clock_i(clock_i), .reset_i(reset_i), .cfg(psd_if_inst),
        .ref_select_i(sel), .crystal_reference_in_i(crystal_reference_in),
        .external_reference_in_i(ext), .vco_clock_i(vco),
        .comparison_ref_o(cmp), .feedback_o(fb), .pump_up_o(up),
        .pump_down_o(dn), .synth_clock_out_o(synth), .monitor_o(mon),
        .loop_divider_o(m_v), .output_divider_o(n_v),
        .observe_select_o(t_v));
    psd_checker psd_checker_inst (
        .clock_i(clock_i), .reset_i(reset_i),
        .m_out(psd_if_inst.m_out), .n_out(psd_if_inst.n_out),
        .par_oe(psd_if_inst.par_oe), .p_load_n(psd_if_inst.p_load_n),
        .s_clock(psd_if_inst.s_clock), .s_data(psd_if_inst.s_data),
        .s_load(psd_if_inst.s_load), .m_pin(psd_if_inst.m_pin),
        .n_pin(psd_if_inst.n_pin));
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge clock_i); while (hreadyout !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clock_i); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Go, then poll busy; four more edges for sync and latch
    task automatic run(input logic [31:0] ctrl);
        int i;
        i = 0;
        ahb(1, 8'h00, ctrl);
        repeat (3) @(posedge clock_i);
        do begin ahb(0, 8'h08, 0); i++; end
        while (rd[0] !== 1'b0 && i < 500);
        `CHECK("busy", 1'b0, rd[0])
        repeat (4) @(posedge clock_i);
    endtask
    task automatic measure;
        logic [2:0] p;
        c_r = 0; s_r = 0; f_r = 0; b_r = 0; o_r = 0; p = 0;
        repeat (1024) begin
            @(posedge clock_i);
            c_r += cmp & ~p[1];
            s_r += synth & ~p[0];
            o_r += mon & ~p[2];
            f_r += fb;
            b_r += up & dn;
            p = {mon, cmp, synth};
        end
    endtask
    function automatic logic near(input int got, input int e);
        return got >= e - 1 && got <= e + 1;
    endfunction
    task print_verdict;
        $display("Checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge clock_i);
        reset_i <= 0;
        repeat (6) @(posedge clock_i);
        `CHECK("m_idle", 9'h1FF, m_v)
        `CHECK("n_idle", 2'h3, n_v)
        `CHECK("t_idle", 3'h0, t_v)
        `CHECK("mon_idle", 1'b0, mon)
        ahb(0, 8'h0C, 0);
        `CHECK("unmapped", 32'h0, rd)
        `CHECK("hresp", 1'b0, hresp)
        // Serial while parallel load still low must not land
        ahb(1, 8'h04, {18'h0, 3'h5, 2'h0, 9'd300});
        run(32'h1);
        `CHECK("ser_blocked", 9'h1FF, m_v)
        `CHECK("refused", 1'b1, rd[2])
        `CHECK("pload_low", 1'b0, rd[3])
        m_e = 9'(200 + {$random(seed)} % 201);
        n_e = 2'($random(seed));
        ahb(1, 8'h04, {21'h0, n_e, m_e});
        ahb(1, 8'h00, 32'h4);
        repeat (5) @(posedge clock_i);
        `CHECK("m_transp", m_e, m_v)
        run(32'h6);
        `CHECK("m_par", m_e, m_v)
        `CHECK("n_par", n_e, n_v)
        `CHECK("pload_high", 1'b1, rd[3])
        ahb(1, 8'h04, {21'h0, ~n_e, m_e ^ 9'h1});
        repeat (6) @(posedge clock_i);
        `CHECK("m_held", m_e, m_v)
        ahb(0, 8'h00, 0);
        `CHECK("ctrl_rd", 32'h4, rd)
        for (int i = 0; i < 2; i++) begin
            ahb(1, 8'h04, {21'h0, n_e, i ? 9'd401 : 9'd199});
            run(32'h1);
            `CHECK("m_range", m_e, m_v)
            `CHECK("ref_bit", 1'b1, rd[2])
        end
        $display("parallel and refusal tests done");
        for (int t = 0; t < 8; t++) begin
            m_e = t == 0 ? 9'd400 : 9'(200 + {$random(seed)} % 201);
            n_e = 2'(t);
            sel <= t[0];
            ref_c = t[0] ? 8 : 12;
            ahb(1, 8'h04, {18'h0, 3'(t), n_e, m_e});
            run(32'h1);
            `CHECK("m_ser", m_e, m_v)
            `CHECK("n_ser", n_e, n_v)
            `CHECK("t_ser", 3'(t), t_v)
            `CHECK("unsettled", 1'b0, rd[1])
            measure;
            c_e = 1024 / (16 * ref_c);
            s_e = 256 / (n_e == 2'h3 ? 1 : 2 << n_e);
            f_e = 256 / m_e;
            `CHECK("cmp_rate", 1'b1, near(c_r, c_e))
            `CHECK("out_rate", 1'b1, near(s_r, s_e))
            `CHECK("fb_rate", 1'b1, near(f_r, f_e))
            `CHECK("pump_both", 0, b_r)
            if (t < 5)
                `CHECK("mon_rate", 1'b1, near(o_r, t == 0 ? 0 :
                t == 1 ? c_e : t == 2 ? f_e : t == 3 ? 256 : s_e))
            ahb(0, 8'h08, 0);
            `CHECK("settled", 1'b1, rd[1])
        end
        $display("serial tests done");
        // Second parallel load: load pin falls again, observe bits clear
        m_e = 9'(200 + {$random(seed)} % 201);
        n_e = 2'($random(seed));
        ahb(1, 8'h04, {21'h0, n_e, m_e});
        run(32'h6);
        `CHECK("m_par2", m_e, m_v)
        `CHECK("n_par2", n_e, n_v)
        `CHECK("t_par", 3'h0, t_v)
        $display("reload test done");
        print_verdict;
    end
endmodule
